/* logic/serdes_sync_status_ctrl.sv */
// Sync request generator, lane buffer status and test controls behind the serial register port
`include "serdes_sync_params.svh"

module serdes_sync_status_ctrl (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst,
  // Serial register port pins
  input  wire serdes_sync_pkg::spi_pins_t spi_in,
  output logic                           spi_sdo,
  output logic                           spi_sdo_oe,
  // Elastic buffer flags, bit n for lane n
  input  wire logic [7:0]                lane_buf_full,
  input  wire logic [7:0]                lane_buf_empty,
  // Alignment events from the lane deframers
  input  wire serdes_sync_pkg::align_evt_t align_evt,
  input  wire logic                      multiframe_end_event,
  input  wire logic [4:0]                frame_octets,
  // Link and test outputs
  output logic                           sync_request_out_n,
  output logic                           bit_error_test_clock_ungate,
  output logic [1:0]                     test_pattern_select
);
  import serdes_sync_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0]  s1_q;
  logic [2:0]  s2_q;
  logic [2:0]  s3_q;
  logic [2:0]  stable_q;
  logic [2:0]  stable_d;
  logic        sclk_prev_q;
  spi_pins_t   pin_st;

  // A change only counts once the second and third stages agree
  assign stable_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & stable_q);
  assign pin_st   = spi_pins_t'(stable_q);

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_q        <= `PIN_IDLE;
      s2_q        <= `PIN_IDLE;
      s3_q        <= `PIN_IDLE;
      stable_q    <= `PIN_IDLE;
      sclk_prev_q <= 1'b0;
    end else begin
      s1_q        <= spi_in;
      s2_q        <= s1_q;
      s3_q        <= s2_q;
      stable_q    <= stable_d;
      sclk_prev_q <= pin_st.sclk;
    end
  end

  // ----------------------------------------------------------------
  // Serial frame decode
  // ----------------------------------------------------------------
  logic [4:0]  bit_cnt_q;
  logic [14:0] instr_q;
  logic [7:0]  wdat_q;
  logic [14:0] addr_q;
  logic        rd_q;
  logic [7:0]  rd_shift_q;
  logic        sdo_q;
  logic        sdo_oe_q;
  wire         active   = ~pin_st.cs_n;
  wire         sclk_up  = active & pin_st.sclk & ~sclk_prev_q;
  wire         sclk_dn  = active & ~pin_st.sclk & sclk_prev_q;
  wire         take_bit = sclk_up & (bit_cnt_q < `SPI_BITS);
  wire [15:0]  instr_full = {instr_q, pin_st.sdi};
  wire         load_rd  = take_bit & (bit_cnt_q == `SPI_LAST_INSTR) & instr_full[15];
  wire         wr_stb   = take_bit & (bit_cnt_q == `SPI_LAST_BIT) & ~rd_q;
  wire [7:0]   wr_data  = {wdat_q[6:0], pin_st.sdi};
  wire         shift_out = sclk_dn & sdo_oe_q & (bit_cnt_q >= `SPI_FIRST_DATA) &
                           (bit_cnt_q <= `SPI_LAST_BIT);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [`MASK_MSB:0] mask_q;
  logic [7:0]         len_q;
  logic [7:0]         test_en_q;
  logic [1:0]         pat_q;
  logic [7:0]         mf_cnt_q;
  logic [7:0]         mf_period_q;

  function automatic logic hit(input logic [14:0] a, input logic [14:0] off);
    hit = (a == off);
  endfunction

  // Status bytes are sampled at the instant of the read, so no flag is held or cleared
  wire [7:0] rd_byte =
    hit(instr_full[14:0], `ADDR_BUF_FULL)  ? lane_buf_full :                         // see RULE_01 see RULE_02 see RULE_11
    hit(instr_full[14:0], `ADDR_BUF_EMPTY) ? lane_buf_empty :                        // see RULE_03 see RULE_11
    hit(instr_full[14:0], `ADDR_SYNC_MASK) ? {5'h00, mask_q} :
    hit(instr_full[14:0], `ADDR_SYNC_LEN)  ? len_q :
    hit(instr_full[14:0], `ADDR_MF_PERIOD) ? mf_period_q :                           // see RULE_08
    hit(instr_full[14:0], `ADDR_TEST_EN)   ? test_en_q :
    hit(instr_full[14:0], `ADDR_TEST_CTRL) ? {4'h0, pat_q, 2'h0} : 8'h00;

  always_ff @(posedge mclk) begin
    if (rst) begin
      bit_cnt_q  <= 5'h00;
      instr_q    <= 15'h0000;
      wdat_q     <= `REG_RESET;
      addr_q     <= 15'h0000;
      rd_q       <= 1'b0;
      rd_shift_q <= `REG_RESET;
      sdo_q      <= 1'b0;
      sdo_oe_q   <= 1'b0;
    end else if (!active) begin
      bit_cnt_q  <= 5'h00;
      sdo_oe_q   <= 1'b0;
    end else begin
      if (take_bit) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
        if (bit_cnt_q <= `SPI_LAST_INSTR) begin
          instr_q <= instr_full[14:0];
        end else begin
          wdat_q  <= wr_data;
        end
      end
      if (take_bit && bit_cnt_q == `SPI_LAST_INSTR) begin
        addr_q <= instr_full[14:0];
        rd_q   <= instr_full[15];
      end
      if (load_rd) begin
        sdo_oe_q   <= 1'b1;
        sdo_q      <= rd_byte[7];
        rd_shift_q <= {rd_byte[6:0], 1'b0};
      end else if (shift_out) begin
        sdo_q      <= rd_shift_q[7];
        rd_shift_q <= {rd_shift_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mask_q    <= 3'h0;
      len_q     <= `REG_RESET;
      test_en_q <= `REG_RESET;
      pat_q     <= 2'h0;
    end else if (wr_stb) begin
      if (hit(addr_q, `ADDR_SYNC_MASK)) begin
        mask_q <= wr_data[`MASK_MSB:0];
      end
      if (hit(addr_q, `ADDR_SYNC_LEN)) begin
        len_q <= wr_data;
      end
      if (hit(addr_q, `ADDR_TEST_EN)) begin
        test_en_q <= wr_data;                                                        // see RULE_09
      end
      if (hit(addr_q, `ADDR_TEST_CTRL)) begin
        pat_q <= wr_data[`PAT_SEL_MSB:`PAT_SEL_LSB];                                 // see RULE_10
      end
    end
  end

  // ----------------------------------------------------------------
  // Multiframe period measurement
  // ----------------------------------------------------------------
  // The first report after reset covers a partial multiframe; it settles at the second marker
  always_ff @(posedge mclk) begin
    if (rst) begin
      mf_cnt_q    <= 8'h00;
      mf_period_q <= `REG_RESET;
    end else if (multiframe_end_event) begin
      mf_cnt_q    <= 8'h00;
      mf_period_q <= (mf_cnt_q == `PERIOD_MAX) ? `PERIOD_MAX : mf_cnt_q + 8'h01;      // see RULE_08
    end else if (mf_cnt_q != `PERIOD_MAX) begin
      mf_cnt_q    <= mf_cnt_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Sync request generator
  // ----------------------------------------------------------------
  sync_state_t state_q;
  sync_state_t state_d;
  logic [7:0]  cnt_q;
  logic [7:0]  cnt_d;
  logic        sync_n_q;
  wire         cause_req = align_evt.sync_req |
                           (align_evt.frame_loss & mask_q[`MASK_FRAME_BIT]) |         // see RULE_05
                           (align_evt.multiframe_loss & mask_q[`MASK_MF_BIT]);        // see RULE_04
  // Half a cycle cannot be shown on this clock, so the error pulse rounds up to whole cycles
  wire [7:0]   err_cycles = {4'h0, len_q[`ERR_LEN_MSB:`ERR_LEN_LSB]} + 8'h01;        // see RULE_06
  wire [7:0]   req_octets = 8'(`REQ_BASE_FRAMES * frame_octets + `REQ_BASE_OCTETS + `PCLK_OCTETS - 1);
  wire [7:0]   req_cycles = 8'(req_octets / `PCLK_OCTETS) +
                            {4'h0, len_q[`REQ_LEN_MSB:`REQ_LEN_LSB]};                 // see RULE_07

  // A resync request overrides a running error pulse and is held while its cause lasts
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      S_IDLE: begin
        if (cause_req) begin
          state_d = S_REQ_LOW;
          cnt_d   = req_cycles - 8'h01;
        end else if (align_evt.err_report) begin
          state_d = S_ERR_LOW;
          cnt_d   = err_cycles - 8'h01;
        end
      end
      S_ERR_LOW: begin
        if (cause_req) begin
          state_d = S_REQ_LOW;
          cnt_d   = req_cycles - 8'h01;
        end else if (cnt_q == 8'h00) begin
          state_d = S_IDLE;
        end else begin
          cnt_d   = cnt_q - 8'h01;
        end
      end
      S_REQ_LOW: begin
        if (cnt_q != 8'h00) begin
          cnt_d   = cnt_q - 8'h01;
        end else if (cause_req) begin
          cnt_d   = req_cycles - 8'h01;
        end else begin
          state_d = S_IDLE;
        end
      end
      default: begin
        state_d = S_IDLE;
        cnt_d   = 8'h00;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q  <= S_IDLE;
      cnt_q    <= 8'h00;
      sync_n_q <= 1'b1;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      sync_n_q <= (state_d == S_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sync_request_out_n          = sync_n_q;
  assign spi_sdo                     = sdo_q;
  assign spi_sdo_oe                  = sdo_oe_q;
  assign bit_error_test_clock_ungate = test_en_q[`TEST_EN_BIT];
  assign test_pattern_select         = pat_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [7:0] low_run_q;
  logic       kind_err_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      low_run_q  <= 8'h00;
      kind_err_q <= 1'b0;
    end else begin
      low_run_q  <= sync_n_q ? 8'h00 : low_run_q + 8'h01;
      kind_err_q <= (state_d == S_ERR_LOW) ? (state_q == S_IDLE) | kind_err_q : 1'b0;
    end
  end

  a_full_snapshot: assert property (@(posedge mclk) disable iff (rst) // see RULE_01 see RULE_02
    load_rd && hit(instr_full[14:0], `ADDR_BUF_FULL) |=> {sdo_q, rd_shift_q[7:1]} == $past(lane_buf_full))
    else $error("full status read does not match live flags");
  a_empty_snapshot: assert property (@(posedge mclk) disable iff (rst) // see RULE_03 see RULE_11
    load_rd && hit(instr_full[14:0], `ADDR_BUF_EMPTY) |=> {sdo_q, rd_shift_q[7:1]} == $past(lane_buf_empty))
    else $error("empty status read does not match live flags");
  a_mf_enabled: assert property (@(posedge mclk) disable iff (rst) // see RULE_04
    align_evt.multiframe_loss && mask_q[`MASK_MF_BIT] |=> !sync_request_out_n && state_q == S_REQ_LOW)
    else $error("enabled multiframe loss did not request sync");
  a_mf_masked: assert property (@(posedge mclk) disable iff (rst) // see RULE_04
    state_q == S_IDLE && align_evt == 4'h2 && !mask_q[`MASK_MF_BIT] |=> sync_request_out_n)
    else $error("masked multiframe loss requested sync");
  a_frame_enabled: assert property (@(posedge mclk) disable iff (rst) // see RULE_05
    align_evt.frame_loss && mask_q[`MASK_FRAME_BIT] |=> !sync_request_out_n && state_q == S_REQ_LOW)
    else $error("enabled frame loss did not request sync");
  a_frame_masked: assert property (@(posedge mclk) disable iff (rst) // see RULE_05
    state_q == S_IDLE && align_evt == 4'h4 && !mask_q[`MASK_FRAME_BIT] |=> sync_request_out_n)
    else $error("masked frame loss requested sync");
  a_err_length: assert property (@(posedge mclk) disable iff (rst) // see RULE_06
    $rose(sync_request_out_n) && $past(kind_err_q) |-> low_run_q == err_cycles)
    else $error("error report low time wrong");
  a_req_length: assert property (@(posedge mclk) disable iff (rst) // see RULE_07
    $rose(sync_request_out_n) && !$past(kind_err_q) |-> low_run_q >= req_cycles)
    else $error("sync request low time too short");
  a_mf_period: assert property (@(posedge mclk) disable iff (rst) // see RULE_08
    multiframe_end_event && mf_cnt_q != `PERIOD_MAX |=> mf_period_q == $past(mf_cnt_q) + 8'h01)
    else $error("multiframe period report wrong");
  a_test_ungate: assert property (@(posedge mclk) disable iff (rst) // see RULE_09
    wr_stb && hit(addr_q, `ADDR_TEST_EN) |=> bit_error_test_clock_ungate == $past(wr_data[`TEST_EN_BIT]))
    else $error("test clock ungate does not follow write");
  a_pattern_sel: assert property (@(posedge mclk) disable iff (rst) // see RULE_10
    wr_stb && hit(addr_q, `ADDR_TEST_CTRL) |=> test_pattern_select == $past(wr_data[`PAT_SEL_MSB:`PAT_SEL_LSB]))
    else $error("pattern select does not follow write");

endmodule // serdes_sync_status_ctrl

/* logic/serdes_sync_params.svh */
// Register offsets, field positions, reset values and timing counts of the sync and status control
// How it works
// RULE_01 - Full status bits 5..7 show lanes 5..7
// RULE_02 - Full status bits 0..4 show lanes 0..4
// RULE_03 - Empty status bit n shows lane n
// RULE_04 - Multiframe loss requests sync only when enabled
// RULE_05 - Frame loss requests sync only when enabled
// RULE_06 - Error report low: half cycle plus field; the code gives one whole cycle plus field
// RULE_07 - Request low: 5 frames+9 octets plus field
// RULE_08 - Report multiframe period in parallel-clock cycles
// RULE_09 - Test enable bit ungates bit-error test clocks
// RULE_10 - Two-bit selector picks PRBS7, PRBS15 or PRBS31
// RULE_11 - Status reads are live, without side effects
// RULE_12 - Transmitter tells short error from long request
`ifndef SERDES_SYNC_PARAMS_SVH
`define SERDES_SYNC_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_BUF_FULL      15'h030C
`define ADDR_BUF_EMPTY     15'h030D
`define ADDR_SYNC_MASK     15'h0311
`define ADDR_SYNC_LEN      15'h0312
`define ADDR_MF_PERIOD     15'h0313
`define ADDR_TEST_EN       15'h0315
`define ADDR_TEST_CTRL     15'h0316

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define MASK_FRAME_BIT     0
`define MASK_MF_BIT        2
`define MASK_MSB           2
`define ERR_LEN_MSB        7
`define ERR_LEN_LSB        4
`define REQ_LEN_MSB        3
`define REQ_LEN_LSB        0
`define TEST_EN_BIT        0
`define PAT_SEL_MSB        3
`define PAT_SEL_LSB        2
`define REG_RESET          8'h00
`define PIN_IDLE           3'h2
`define PERIOD_MAX         8'hFF

// ----------------------------------------------------------------
// Serial port framing and timing
// ----------------------------------------------------------------
`define SPI_LAST_INSTR     5'h0F
`define SPI_FIRST_DATA     5'h11
`define SPI_LAST_BIT       5'h17
`define SPI_BITS           5'h18
`define PCLK_OCTETS        4
`define REQ_BASE_FRAMES    5
`define REQ_BASE_OCTETS    9

`endif

/* logic/serdes_sync_pkg.sv */
// Types shared by the sync and status control
package serdes_sync_pkg;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdi;
  } spi_pins_t;

  typedef struct packed {
    logic sync_req;
    logic frame_loss;
    logic multiframe_loss;
    logic err_report;
  } align_evt_t;

  typedef enum logic [1:0] {
    S_IDLE,
    S_ERR_LOW,
    S_REQ_LOW
  } sync_state_t;

endpackage : serdes_sync_pkg

/* verification/sync_tx_model.sv */
// Transmitter-side model that times each low period of the sync request
module sync_tx_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Sync request from the receiver
  input  wire logic       sync_n,
  // Last low length in mclk cycles, count of low periods
  output logic [7:0]      low_len,
  output logic [7:0]      n_low
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] cnt_q;

  // Length tells a short error report from a long resync request
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_q   <= 8'h00;
      low_len <= 8'h00;
      n_low   <= 8'h00;
    end else if (!sync_n) begin
      cnt_q <= cnt_q + 8'h01;
    end else if (cnt_q != 8'h00) begin
      low_len <= cnt_q;
      n_low   <= n_low + 8'h01;
      cnt_q   <= 8'h00;
    end
  end
endmodule // sync_tx_model

/* verification/serdes_sync_status_ctrl_tb_top.sv */
// Self-checking bench for the sync and status control
`include "serdes_sync_params.svh"
module serdes_sync_status_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import serdes_sync_pkg::*;

  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic       mclk, rst, sdo, sdo_oe, sync_n, ungate, mfe;
  logic [1:0] pat;
  logic [4:0] fo;
  logic [7:0] full, empty, low_len, n_low, rd;
  spi_pins_t  spi;
  align_evt_t evt;
  int         n_mismatch, checks, cyc;
  // Frame length four octets, so the request base is eight cycles
  localparam int F = 4;
  localparam int BASE = (5 * F + 9 + 3) / 4;

  serdes_sync_status_ctrl uut (
    .mclk(mclk), .rst(rst), .spi_in(spi), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe),
    .lane_buf_full(full), .lane_buf_empty(empty), .align_evt(evt),
    .multiframe_end_event(mfe), .frame_octets(fo), .sync_request_out_n(sync_n),
    .bit_error_test_clock_ungate(ungate), .test_pattern_select(pat)
  );
  sync_tx_model tx (.mclk(mclk), .rst(rst), .sync_n(sync_n), .low_len(low_len), .n_low(n_low));

  always #10 mclk = ~mclk;

  // Cut a hang short; a full run needs about 5800 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("Mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Half period of sclk is four mclk; read bits are taken at the end of the high phase,
  // since each shift lands about five mclk after the falling edge before it.
  // A released data line is taken as pulled low, so a missing enable shows up as bad data
  task automatic spi_acc(input logic r, input logic [14:0] a, input logic [7:0] wd, output logic [7:0] rv);
    logic [23:0] f;
    f = {r, a, wd};
    rv = 8'h00;
    spi.cs_n = 1'b0;
    #80;
    for (int i = 23; i >= 0; i--) begin
      spi.sdi = f[i];
      #80;
      spi.sclk = 1'b1;
      #80;
      if (i < 8) rv[i] = sdo & sdo_oe;
      spi.sclk = 1'b0;
    end
    #80;
    spi.cs_n = 1'b1;
    #160;
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    spi_acc(1'b0, a, d, rd);
  endtask

  task automatic rdc(input string nm, input logic [14:0] a, input logic [7:0] exp);
    spi_acc(1'b1, a, 8'h00, rd);
    check(nm, rd, exp);
  endtask

  // One-cycle event, then the low length seen by the transmitter (0 = none)
  task automatic fire(input string nm, input align_evt_t e, input logic [7:0] exp);
    logic [7:0] n0;
    n0 = n_low;
    evt = e;
    #20;
    evt = '0;
    for (int k = 0; k < 80 && n_low == n0; k++) #20;
    check(nm, (n_low == n0) ? 8'h00 : low_len, exp);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check("sync_n", {7'h00, sync_n}, 8'h01);
    check("ungate", {7'h00, ungate}, 8'h00);
    check("pattern", {6'h00, pat}, 8'h00);
    rdc("empty", `ADDR_BUF_EMPTY, 8'h00);
    rdc("mask", `ADDR_SYNC_MASK, 8'h00);
    rdc("len", `ADDR_SYNC_LEN, 8'h00);
    rdc("period", `ADDR_MF_PERIOD, 8'h00);
    rdc("test_en", `ADDR_TEST_EN, 8'h00);
  endtask

  // Flags change between reads; each read must show the live state
  task automatic t_status();
    full = 8'hA5;
    empty = 8'h3C;
    rdc("full", `ADDR_BUF_FULL, 8'hA5);
    rdc("empty", `ADDR_BUF_EMPTY, 8'h3C);
    full = 8'h5A;
    empty = 8'hC3;
    rdc("full", `ADDR_BUF_FULL, 8'h5A);
    rdc("empty", `ADDR_BUF_EMPTY, 8'hC3);
    rdc("empty", `ADDR_BUF_EMPTY, 8'hC3);
    check("sdo_oe", {7'h00, sdo_oe}, 8'h00);
  endtask

  task automatic t_masks();
    wr(`ADDR_SYNC_MASK, 8'hFF);
    rdc("mask", `ADDR_SYNC_MASK, 8'h07);
    wr(`ADDR_SYNC_MASK, 8'h00);
    fire("frame_off", 4'b0100, 8'h00);
    fire("mf_off", 4'b0010, 8'h00);
    wr(`ADDR_SYNC_MASK, 8'h01);
    fire("frame_on", 4'b0100, 8'(BASE));
    fire("mf_off", 4'b0010, 8'h00);
    wr(`ADDR_SYNC_MASK, 8'h04);
    fire("mf_on", 4'b0010, 8'(BASE));
    fire("frame_off", 4'b0100, 8'h00);
  endtask

  // Zero, largest and mixed settings of both length fields
  task automatic t_lengths();
    logic [7:0] v[3] = '{8'h00, 8'hF1, 8'h3F};
    foreach (v[i]) begin
      wr(`ADDR_SYNC_LEN, v[i]);
      fire("err_len", 4'b0001, 8'(v[i][7:4]) + 8'h01);
      fire("req_len", 4'b1000, 8'(BASE) + 8'(v[i][3:0]));
    end
    // Longest frame: base grows to 5*16+9 octets, rounded up to whole cycles
    fo = 5'h10;
    fire("req_len_f16", 4'b1000, 8'((5 * 16 + 9 + 3) / 4 + 15));
    fo = 5'h01;
    fire("req_len_f1", 4'b1000, 8'((5 * 1 + 9 + 3) / 4 + 15));
    fo = 5'(F);
  endtask

  task automatic t_period();
    mfe = 1'b1;
    #20;
    mfe = 1'b0;
    #220;
    mfe = 1'b1;
    #20;
    mfe = 1'b0;
    rdc("period", `ADDR_MF_PERIOD, 8'h0C);
  endtask

  task automatic t_test();
    wr(`ADDR_TEST_EN, 8'h01);
    check("ungate", {7'h00, ungate}, 8'h01);
    rdc("test_en", `ADDR_TEST_EN, 8'h01);
    for (int p = 0; p < 3; p++) begin
      wr(`ADDR_TEST_CTRL, 8'(p << 2));
      check("pattern", {6'h00, pat}, 8'(p));
    end
    wr(`ADDR_TEST_EN, 8'h00);
    check("ungate", {7'h00, ungate}, 8'h00);
    rdc("unmapped", 15'h0320, 8'h00);
  endtask

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    spi = '{1'b0, 1'b1, 1'b0};
    evt = '0;
    mfe = 1'b0;
    fo = 5'(F);
    full = 8'h00;
    empty = 8'h00;
    repeat (16) @(posedge mclk);
    #1;
    rst = 1'b0;
    #80;
    t_reset();
    t_status();
    t_masks();
    t_lengths();
    t_period();
    t_test();
    conclude();
  end
endmodule // serdes_sync_status_ctrl_tb_top
